// *** pkg/apfm_pkg.sv ***
// constants, masks and types of the alternate pin function multiplexer
package apfm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NPIN   = 16;
  localparam int NBIT   = 14;
  localparam int NFIRST = 8;
  localparam int NCONF  = 7;

  localparam logic [ADDR_W-1:0] OFF_FIRST  = 8'h50;
  localparam logic [ADDR_W-1:0] OFF_SECOND = 8'h54;
  localparam logic [ADDR_W-1:0] OFF_CONF   = 8'hA0;
  localparam logic [ADDR_W-1:0] OFF_PA_DRV = 8'hC0;
  localparam logic [ADDR_W-1:0] OFF_PB_DRV = 8'hC4;
  localparam logic [ADDR_W-1:0] OFF_PD_DRV = 8'hCC;

  localparam logic [DATA_W-1:0] MASK_FIRST  = 32'h6D37_9FE3;
  localparam logic [DATA_W-1:0] MASK_SECOND = 32'h0F3F_0000;
  localparam logic [DATA_W-1:0] MASK_PA_DRV = 32'h0000_0C00;
  localparam logic [DATA_W-1:0] MASK_PB_DRV = 32'h0000_71F0;
  localparam logic [DATA_W-1:0] MASK_PD_DRV = 32'h0000_0F00;
  localparam logic [DATA_W-1:0] RST_ZERO    = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // route codes: for two-bit pins the code is {alt, primary}, or CODE_RSVD for a reserved combination
  typedef logic [2:0] apfm_code_t;
  localparam apfm_code_t CODE_GPIO = 3'h0;
  localparam apfm_code_t CODE_F01  = 3'h1;
  localparam apfm_code_t CODE_F10  = 3'h2;
  localparam apfm_code_t CODE_F11  = 3'h3;
  localparam apfm_code_t CODE_RSVD = 3'h4;
  localparam apfm_code_t CODE_F00  = 3'h5;

  // pin indices of the route vector
  localparam int P_PB12 = 0;
  localparam int P_PA15 = 1;
  localparam int P_PC3  = 2;
  localparam int P_PC2  = 3;
  localparam int P_PC1  = 4;
  localparam int P_PC0  = 5;
  localparam int P_PB9  = 6;
  localparam int P_PB10 = 7;
  localparam int P_PD5  = 8;
  localparam int P_PD4  = 9;
  localparam int P_PD3  = 10;
  localparam int P_PD2  = 11;
  localparam int P_PD1  = 12;
  localparam int P_PD0  = 13;
  localparam int P_PF3  = 14;
  localparam int P_PF2  = 15;

  // alt bit positions; the first eight sit in the first register
  localparam int ALT_POS [NBIT] = '{10, 9, 8, 7, 6, 5, 1, 0, 21, 20, 19, 18, 17, 16};
  // reserved combinations, bit index is {alt, primary}
  localparam logic [3:0] RSVD_MASK [NBIT] = '{4'h4, 4'h0, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4,
                                             4'h4, 4'h2, 4'h2, 4'h0, 4'h0, 4'h0, 4'h2};
  localparam int PF3_HI = 27;
  localparam int PF3_LO = 26;
  localparam int PF2_HI = 25;
  localparam int PF2_LO = 24;
  localparam logic [1:0] PF_RSVD = 2'h1;
  localparam logic [1:0] PF_F00  = 2'h0;

  typedef struct packed {
    logic [15:0] pa;
    logic [15:0] pb;
    logic [15:0] pd;
  } apfm_drive_t;
endpackage

// *** rtl/apfm_top.sv ***
// alternate pin function multiplexer with axi4-lite register slave
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module apfm_top (
  // clock and reset
  input  wire logic                                 mclk,
  input  wire logic                                 rstn,
  // axi4-lite write address and data
  input  wire logic [apfm_pkg::ADDR_W-1:0]          s_axi_awaddr,
  input  wire logic [2:0]                           s_axi_awprot,
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire logic [apfm_pkg::DATA_W-1:0]          s_axi_wdata,
  input  wire logic [3:0]                           s_axi_wstrb,
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                                s_axi_bresp,
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  // axi4-lite read
  input  wire logic [apfm_pkg::ADDR_W-1:0]          s_axi_araddr,
  input  wire logic [2:0]                           s_axi_arprot,
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  output logic [apfm_pkg::DATA_W-1:0]               s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready,
  // primary select bits, one per routed pin, and conflict detectors
  input  wire logic [apfm_pkg::NPIN-1:0]            pin_primary_select,
  input  wire logic [apfm_pkg::NCONF-1:0]           conflict_in,
  // routing and drive strength
  output apfm_pkg::apfm_code_t [apfm_pkg::NPIN-1:0] pin_route,
  output apfm_pkg::apfm_drive_t                     pin_drive
);

  function automatic apfm_pkg::apfm_code_t route_code(input logic alt, input logic prim,
                                                      input logic [3:0] rsvd);
    logic [1:0] idx;
    idx = {alt, prim};
    if (rsvd[idx])
      return apfm_pkg::CODE_RSVD;
    return {1'b0, idx};
  endfunction

  function automatic apfm_pkg::apfm_code_t pf_code(input logic [1:0] fld, input logic prim);
    if (!prim)
      return apfm_pkg::CODE_GPIO;
    if (fld == apfm_pkg::PF_RSVD)
      return apfm_pkg::CODE_RSVD;
    if (fld == apfm_pkg::PF_F00)
      return apfm_pkg::CODE_F00;
    return {1'b0, fld};
  endfunction

  // byte-lane merge; reserved bits are forced to zero
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r & mask;
  endfunction

  // write and read channel holding registers
  logic                          aw_hold_q;
  logic [apfm_pkg::ADDR_W-1:0]   aw_addr_q;
  logic                          w_hold_q;
  logic [apfm_pkg::DATA_W-1:0]   w_data_q;
  logic [3:0]                    w_strb_q;
  logic                          bvalid_q;
  logic [1:0]                    bresp_q;
  logic                          rvalid_q;
  logic [1:0]                    rresp_q;
  logic [apfm_pkg::DATA_W-1:0]   rdata_q;

  // register file
  logic [apfm_pkg::DATA_W-1:0]   first_q;
  logic [apfm_pkg::DATA_W-1:0]   second_q;
  logic [apfm_pkg::DATA_W-1:0]   pa_q;
  logic [apfm_pkg::DATA_W-1:0]   pb_q;
  logic [apfm_pkg::DATA_W-1:0]   pd_q;
  logic [apfm_pkg::NCONF-1:0]    conf_q;
  logic [apfm_pkg::DATA_W-1:0]   first_d;
  logic [apfm_pkg::DATA_W-1:0]   second_d;
  logic [apfm_pkg::DATA_W-1:0]   pa_d;
  logic [apfm_pkg::DATA_W-1:0]   pb_d;
  logic [apfm_pkg::DATA_W-1:0]   pd_d;

  apfm_pkg::apfm_code_t [apfm_pkg::NPIN-1:0] route_d;
  apfm_pkg::apfm_code_t [apfm_pkg::NPIN-1:0] route_q;
  logic [apfm_pkg::NBIT-1:0]                 alt_bit;

  wire do_write = aw_hold_q && w_hold_q;
  wire ar_take  = s_axi_arvalid && s_axi_arready;

  // write decode
  wire ws_first  = aw_addr_q == apfm_pkg::OFF_FIRST;
  wire ws_second = aw_addr_q == apfm_pkg::OFF_SECOND;
  wire ws_conf   = aw_addr_q == apfm_pkg::OFF_CONF;
  wire ws_pa     = aw_addr_q == apfm_pkg::OFF_PA_DRV;
  wire ws_pb     = aw_addr_q == apfm_pkg::OFF_PB_DRV;
  wire ws_pd     = aw_addr_q == apfm_pkg::OFF_PD_DRV;
  wire ws_hit    = ws_first || ws_second || ws_conf || ws_pa || ws_pb || ws_pd;

  // read decode
  wire rs_first  = s_axi_araddr == apfm_pkg::OFF_FIRST;
  wire rs_second = s_axi_araddr == apfm_pkg::OFF_SECOND;
  wire rs_conf   = s_axi_araddr == apfm_pkg::OFF_CONF;
  wire rs_pa     = s_axi_araddr == apfm_pkg::OFF_PA_DRV;
  wire rs_pb     = s_axi_araddr == apfm_pkg::OFF_PB_DRV;
  wire rs_pd     = s_axi_araddr == apfm_pkg::OFF_PD_DRV;
  wire rs_hit    = rs_first || rs_second || rs_conf || rs_pa || rs_pb || rs_pd;

  // no new write is taken until the response has been accepted
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // reserved bits are masked on write so reads give zero
  assign first_d  = (do_write && ws_first)  ?
                    wmerge(first_q, w_data_q, w_strb_q, apfm_pkg::MASK_FIRST) : first_q;
  assign second_d = (do_write && ws_second) ?
                    wmerge(second_q, w_data_q, w_strb_q, apfm_pkg::MASK_SECOND) : second_q;
  assign pa_d     = (do_write && ws_pa) ?
                    wmerge(pa_q, w_data_q, w_strb_q, apfm_pkg::MASK_PA_DRV) : pa_q;
  assign pb_d     = (do_write && ws_pb) ?
                    wmerge(pb_q, w_data_q, w_strb_q, apfm_pkg::MASK_PB_DRV) : pb_q;
  assign pd_d     = (do_write && ws_pd) ?
                    wmerge(pd_q, w_data_q, w_strb_q, apfm_pkg::MASK_PD_DRV) : pd_q;

  // conflict status has no write path at all
  wire [apfm_pkg::DATA_W-1:0] conf_word = {{(apfm_pkg::DATA_W-apfm_pkg::NCONF){1'b0}},
                                           conf_q};
  wire [apfm_pkg::DATA_W-1:0] rd_word =
    rs_first  ? first_q  :
    rs_second ? second_q :
    rs_conf   ? conf_word :
    rs_pa     ? pa_q     :
    rs_pb     ? pb_q     :
    rs_pd     ? pd_q     : apfm_pkg::RST_ZERO;

  // alt bit of each two-bit pin and its route code
  for (genvar i = 0; i < apfm_pkg::NBIT; i++) begin : g_pin
    if (i < apfm_pkg::NFIRST) begin : g_first
      assign alt_bit[i] = first_q[apfm_pkg::ALT_POS[i]];
    end else begin : g_second
      assign alt_bit[i] = second_q[apfm_pkg::ALT_POS[i]];
    end
    assign route_d[i] = route_code(alt_bit[i], pin_primary_select[i], apfm_pkg::RSVD_MASK[i]);
  end
  assign route_d[apfm_pkg::P_PF3] = pf_code(second_q[apfm_pkg::PF3_HI:apfm_pkg::PF3_LO],
                                            pin_primary_select[apfm_pkg::P_PF3]);
  assign route_d[apfm_pkg::P_PF2] = pf_code(second_q[apfm_pkg::PF2_HI:apfm_pkg::PF2_LO],
                                            pin_primary_select[apfm_pkg::P_PF2]);

  // route is registered so decode hazards never reach a peripheral
  assign pin_route = route_q;
  assign pin_drive = '{pa: pa_q[15:0], pb: pb_q[15:0], pd: pd_q[15:0]};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_hold_q  <= 1'b0;
      w_data_q  <= apfm_pkg::RST_ZERO;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= apfm_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= ws_hit ? apfm_pkg::RESP_OKAY : apfm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= apfm_pkg::RESP_OKAY;
      rdata_q  <= apfm_pkg::RST_ZERO;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rs_hit ? apfm_pkg::RESP_OKAY : apfm_pkg::RESP_SLVERR;
      rdata_q  <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      first_q  <= apfm_pkg::RST_ZERO;
      second_q <= apfm_pkg::RST_ZERO;
      pa_q     <= apfm_pkg::RST_ZERO;
      pb_q     <= apfm_pkg::RST_ZERO;
      pd_q     <= apfm_pkg::RST_ZERO;
      conf_q   <= '0;
      route_q  <= '0;
    end else begin
      first_q  <= first_d;
      second_q <= second_d;
      pa_q     <= pa_d;
      pb_q     <= pb_d;
      pd_q     <= pd_d;
      conf_q   <= conflict_in;
      route_q  <= route_d;
    end
  end

  a_pb12_reserved: assert property (@(posedge mclk) disable iff (!rstn)
    (first_q[10] && !pin_primary_select[apfm_pkg::P_PB12])
      |=> pin_route[apfm_pkg::P_PB12] == apfm_pkg::CODE_RSVD)
    else $error("pb12 reserved combination not flagged");

  a_pa15_clkout: assert property (@(posedge mclk) disable iff (!rstn)
    (first_q[9] && !pin_primary_select[apfm_pkg::P_PA15])
      |=> pin_route[apfm_pkg::P_PA15] == apfm_pkg::CODE_F10)
    else $error("pa15 clock out not routed");

  a_pb10_spi: assert property (@(posedge mclk) disable iff (!rstn)
    (first_q[0] && pin_primary_select[apfm_pkg::P_PB10])
      |=> pin_route[apfm_pkg::P_PB10] == apfm_pkg::CODE_F11)
    else $error("pb10 spi select not routed");

  a_pf3_gpio: assert property (@(posedge mclk) disable iff (!rstn)
    !pin_primary_select[apfm_pkg::P_PF3] |=> pin_route[apfm_pkg::P_PF3] == apfm_pkg::CODE_GPIO)
    else $error("pf3 not gpio with primary bit low");

  a_pf2_i2c: assert property (@(posedge mclk) disable iff (!rstn)
    (pin_primary_select[apfm_pkg::P_PF2] && second_q[25:24] == 2'h2)
      |=> pin_route[apfm_pkg::P_PF2] == apfm_pkg::CODE_F10)
    else $error("pf2 i2c data not routed");

  a_pd5_reserved: assert property (@(posedge mclk) disable iff (!rstn)
    (!second_q[21] && pin_primary_select[apfm_pkg::P_PD5])
      |=> pin_route[apfm_pkg::P_PD5] == apfm_pkg::CODE_RSVD)
    else $error("pd5 reserved combination not flagged");

  a_pd3_spi0: assert property (@(posedge mclk) disable iff (!rstn)
    (!second_q[19] && pin_primary_select[apfm_pkg::P_PD3])
      |=> pin_route[apfm_pkg::P_PD3] == apfm_pkg::CODE_F01)
    else $error("pd3 spi0 output not routed");

  a_conf_read: assert property (@(posedge mclk) disable iff (!rstn)
    (ar_take && rs_conf) |=> (s_axi_rvalid && s_axi_rdata == {25'h0, $past(conf_q)}))
    else $error("conflict status read mismatch");

  a_drive_rsvd: assert property (@(posedge mclk) disable iff (!rstn)
    ((pin_drive.pa & 16'hF3FF) == 16'h0) && ((pin_drive.pb & 16'h8E0F) == 16'h0)
      && ((pin_drive.pd & 16'hF0FF) == 16'h0))
    else $error("reserved drive bit set");

  a_write_route: assert property (@(posedge mclk) disable iff (!rstn)
    (do_write && ws_second && w_strb_q[2] && w_data_q[16] && pin_primary_select[apfm_pkg::P_PD0])
      ##1 pin_primary_select[apfm_pkg::P_PD0]
      |=> pin_route[apfm_pkg::P_PD0] == apfm_pkg::CODE_F11)
    else $error("pd0 route did not follow write");

  a_bresp_timing: assert property (@(posedge mclk) disable iff (!rstn)
    do_write |=> (s_axi_bvalid && !s_axi_awready && !s_axi_wready))
    else $error("write response not raised");

  a_pc3_audio: assert property (@(posedge mclk) disable iff (!rstn)
    (first_q[apfm_pkg::ALT_POS[apfm_pkg::P_PC3]] && pin_primary_select[apfm_pkg::P_PC3])
      |=> pin_route[apfm_pkg::P_PC3] == apfm_pkg::CODE_F11)
    else $error("pc3 audio data out not routed");

  a_pc2_reserved: assert property (@(posedge mclk) disable iff (!rstn)
    (first_q[apfm_pkg::ALT_POS[apfm_pkg::P_PC2]] && !pin_primary_select[apfm_pkg::P_PC2])
      |=> pin_route[apfm_pkg::P_PC2] == apfm_pkg::CODE_RSVD)
    else $error("pc2 reserved combination not flagged");

  a_pb9_reserved: assert property (@(posedge mclk) disable iff (!rstn)
    (first_q[apfm_pkg::ALT_POS[apfm_pkg::P_PB9]] && !pin_primary_select[apfm_pkg::P_PB9])
      |=> pin_route[apfm_pkg::P_PB9] == apfm_pkg::CODE_RSVD)
    else $error("pb9 reserved combination not flagged");

  a_pd4_analog: assert property (@(posedge mclk) disable iff (!rstn)
    (second_q[apfm_pkg::ALT_POS[apfm_pkg::P_PD4]] && pin_primary_select[apfm_pkg::P_PD4])
      |=> pin_route[apfm_pkg::P_PD4] == apfm_pkg::CODE_F11)
    else $error("pd4 analog channel not routed");

  a_pd2_spi2: assert property (@(posedge mclk) disable iff (!rstn)
    (second_q[apfm_pkg::ALT_POS[apfm_pkg::P_PD2]] && !pin_primary_select[apfm_pkg::P_PD2])
      |=> pin_route[apfm_pkg::P_PD2] == apfm_pkg::CODE_F10)
    else $error("pd2 spi2 input not routed");

  a_pd0_reserved: assert property (@(posedge mclk) disable iff (!rstn)
    (!second_q[apfm_pkg::ALT_POS[apfm_pkg::P_PD0]] && pin_primary_select[apfm_pkg::P_PD0])
      |=> pin_route[apfm_pkg::P_PD0] == apfm_pkg::CODE_RSVD)
    else $error("pd0 reserved combination not flagged");

  a_pf3_kbd: assert property (@(posedge mclk) disable iff (!rstn)
    (pin_primary_select[apfm_pkg::P_PF3]
      && second_q[apfm_pkg::PF3_HI:apfm_pkg::PF3_LO] == apfm_pkg::PF_F00)
      |=> pin_route[apfm_pkg::P_PF3] == apfm_pkg::CODE_F00)
    else $error("pf3 keyboard clock not routed");

  a_conf_follow: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) |-> conf_q == $past(conflict_in))
    else $error("conflict status does not follow detectors");

  a_pa_drive_wr: assert property (@(posedge mclk) disable iff (!rstn)
    (do_write && ws_pa && w_strb_q[1]) |=>
      ((pin_drive.pa ^ $past(w_data_q[15:0])) & apfm_pkg::MASK_PA_DRV[15:0]) == 16'h0000)
    else $error("port a drive bits not written");

  a_pb_drive_wr: assert property (@(posedge mclk) disable iff (!rstn)
    (do_write && ws_pb && w_strb_q[1:0] == 2'h3) |=>
      ((pin_drive.pb ^ $past(w_data_q[15:0])) & apfm_pkg::MASK_PB_DRV[15:0]) == 16'h0000)
    else $error("port b drive bits not written");

  a_pd_drive_wr: assert property (@(posedge mclk) disable iff (!rstn)
    (do_write && ws_pd && w_strb_q[1]) |=>
      ((pin_drive.pd ^ $past(w_data_q[15:0])) & apfm_pkg::MASK_PD_DRV[15:0]) == 16'h0000)
    else $error("port d drive bits not written");

  // waits one edge in reset so the very first edge of a run is not judged
  a_reset_zero: assert property (@(posedge mclk)
    (!rstn ##1 !rstn) |-> (pin_route == '0 && pin_drive == '0 && conf_q == '0
      && second_q == apfm_pkg::RST_ZERO && first_q == apfm_pkg::RST_ZERO))
    else $error("register not cleared by reset");

endmodule

// *** bench/apfm_partner.sv ***
// pin-side model: primary selects and conflict detectors seen by the multiplexer
`timescale 1ns/10ps
module apfm_partner (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  // levels requested by the bench
  input  wire logic [apfm_pkg::NPIN-1:0]   prim_req,
  input  wire logic [apfm_pkg::NCONF-1:0]  conf_req,
  // levels at the pins
  output logic      [apfm_pkg::NPIN-1:0]   pin_primary_select,
  output logic      [apfm_pkg::NCONF-1:0]  conflict_in
);
  // registered so every change lands one edge after the request, like a synchronised pin
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_primary_select <= 16'h0000;
      conflict_in        <= 7'h00;
    end else begin
      pin_primary_select <= prim_req;
      conflict_in        <= conf_req;
    end
  end
endmodule

// *** bench/tb.sv ***
// self-checking bench of the alternate pin function multiplexer
`timescale 1ns/10ps
module tb;
  logic                       mclk;
  logic                       rstn;
  logic [7:0]                 awaddr;
  logic [7:0]                 araddr;
  logic                       awvalid;
  logic                       wvalid;
  logic                       arvalid;
  logic [31:0]                wdata;
  logic [3:0]                 wstrb;
  logic                       awready;
  logic                       wready;
  logic                       arready;
  logic                       bvalid;
  logic                       rvalid;
  logic [1:0]                 bresp;
  logic [1:0]                 rresp;
  logic [31:0]                rdata;
  logic [15:0]                prim_req;
  logic [6:0]                 conf_req;
  logic [15:0]                prim;
  logic [6:0]                 conf;
  apfm_pkg::apfm_code_t [15:0] route;
  apfm_pkg::apfm_drive_t      drive;
  int                         fails;
  int                         cmp_count;
  logic [31:0]                seed;
  logic [7:0]                 adr [5];
  logic [31:0]                msk [5];
  logic [31:0]                d;
  logic [31:0]                f;
  logic [31:0]                s;
  logic [1:0]                 r;

  apfm_partner i_apfm_partner (.mclk(mclk), .rstn(rstn), .prim_req(prim_req),
    .conf_req(conf_req), .pin_primary_select(prim), .conflict_in(conf));

  apfm_top i_apfm_top (.mclk(mclk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .pin_primary_select(prim), .conflict_in(conf), .pin_route(route),
    .pin_drive(drive));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // route code of pin i from both alt registers and the primary bits
  function automatic apfm_pkg::apfm_code_t model(int i, logic [31:0] fr, logic [31:0] sc,
                                                logic [15:0] p);
    int         pos [14] = '{10, 9, 8, 7, 6, 5, 1, 0, 21, 20, 19, 18, 17, 16};
    int         rs [14]  = '{2, 0, 2, 2, 2, 2, 2, 2, 1, 1, 0, 0, 0, 1};
    int         c;
    logic [1:0] fld;
    if (i >= 14) begin
      fld = (i == 14) ? sc[27:26] : sc[25:24];
      if (!p[i]) return 3'h0;
      return (fld == 2'h0) ? 3'h5 : (fld == 2'h1) ? 3'h4 : {1'b0, fld};
    end
    c = 2 * ((i < 8) ? fr[pos[i]] : sc[pos[i]]) + p[i];
    return (c != 0 && c == rs[i]) ? 3'h4 : 3'(c);
  endfunction

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] st,
                    output logic [1:0] rsp);
    int n;
    awaddr  <= a;
    wdata   <= dd;
    wstrb   <= st;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rsp = bresp;
        return;
      end
    end
    $display("[ERR] %0t write timed out", $time);
    fails++;
    end_sim();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rsp);
    int n;
    araddr  <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        dd  = rdata;
        rsp = rresp;
        return;
      end
    end
    $display("[ERR] %0t read timed out", $time);
    fails++;
    end_sim();
  endtask

  initial begin
    rstn = 1'b0; awaddr = 8'h00; araddr = 8'h00; awvalid = 1'b0; wvalid = 1'b0;
    arvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; prim_req = 16'h0; conf_req = 7'h0;
    fails = 0; cmp_count = 0; seed = 32'h6EBEB2BD;
    adr = '{apfm_pkg::OFF_FIRST, 8'h54, 8'hC0, 8'hC4, 8'hCC};
    msk = '{apfm_pkg::MASK_FIRST, 32'h0F3F_0000, 32'h0000_0C00, 32'h0000_71F0, 32'h0000_0F00};
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    for (int k = 0; k < 5; k++) begin
      rd(adr[k], d, r);
      chk(d, 32'h0);
    end
    rd(8'hA0, d, r);
    chk(d, 32'h0);
    chk(route, 48'h0);
    chk(drive, 48'h0);
    // all ones to the five masked registers: only the documented bits may stick
    for (int k = 0; k < 5; k++) begin
      wr(adr[k], 32'hFFFF_FFFF, 4'hF, r);
      rd(adr[k], d, r);
      chk({r, d}, {2'h0, msk[k]});
    end
    chk(drive, {16'h0C00, 16'h71F0, 16'h0F00});
    wr(8'hC4, 32'h0, 4'h2, r);
    chk(drive.pb, 16'h00F0);
    wr(8'h58, 32'hFFFF_FFFF, 4'hF, r);
    chk(r, apfm_pkg::RESP_SLVERR);
    rd(8'h58, d, r);
    chk({r, d}, {apfm_pkg::RESP_SLVERR, 32'h0});
    conf_req <= 7'h7F;
    wr(8'hA0, 32'h0, 4'hF, r);
    chk(r, apfm_pkg::RESP_OKAY);
    rd(8'hA0, d, r);
    chk(d, 32'h0000_007F);
    // random selects and pin levels, routing checked 1 ns after the edge on which the write response is seen
    for (int it = 0; it < 60; it++) begin
      f = rnd();
      s = rnd();
      d = rnd();
      prim_req <= d[15:0];
      conf_req <= d[22:16];
      wr(apfm_pkg::OFF_FIRST, f, 4'hF, r);
      wr(8'h54, s, 4'hF, r);
      #1;
      chk(route[0], model(0, f, s, prim_req));
      chk(route[1], model(1, f, s, prim_req));
      chk(route[2], model(2, f, s, prim_req));
      chk(route[3], model(3, f, s, prim_req));
      chk(route[4], model(4, f, s, prim_req));
      chk(route[5], model(5, f, s, prim_req));
      chk(route[6], model(6, f, s, prim_req));
      chk(route[7], model(7, f, s, prim_req));
      chk(route[8], model(8, f, s, prim_req));
      chk(route[9], model(9, f, s, prim_req));
      chk(route[10], model(10, f, s, prim_req));
      chk(route[11], model(11, f, s, prim_req));
      chk(route[12], model(12, f, s, prim_req));
      chk(route[13], model(13, f, s, prim_req));
      chk(route[14], model(14, f, s, prim_req));
      chk(route[15], model(15, f, s, prim_req));
      @(posedge mclk);
      rd(8'hA0, d, r);
      chk(d, {25'h0, conf_req});
    end
    // reset in mid-run: everything written above must fall back to zero
    prim_req <= 16'h0000;
    rstn     <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({bvalid, rvalid, route}, 50'h0);
    chk(drive, 48'h0);
    rstn <= 1'b1;
    @(posedge mclk);
    for (int k = 0; k < 5; k++) begin
      rd(adr[k], d, r);
      chk({r, d}, 34'h0);
    end
    chk(route, 48'h0);
    end_sim();
  end
endmodule
